//--- include/pis_regs.vh
`ifndef PIS_REGS_VH
`define PIS_REGS_VH
// ============================================================
// Register map, byte addresses on the Wishbone slave.
`define PIS_ADR_CTRL 8'h00
`define PIS_ADR_STAT 8'h04
`define PIS_ADR_X 8'h08
`define PIS_ADR_Y 8'h0c
`define PIS_ADR_Z 8'h10
`define PIS_ADR_PI 8'h14
`define PIS_ADR_INT 8'h18
`define PIS_ADR_SQS 8'h1c
`define PIS_ADR_DATA 8'h40
// ============================================================
// Field positions.
`define PIS_CTRL_RUN 0
`define PIS_STAT_BUSY 0
`define PIS_STAT_HOLD 1
`define PIS_STAT_IND1 2
`define PIS_STAT_IND2 3
`define PIS_STAT_ST 4
`define PIS_STAT_PC 8
// ============================================================
// Step codes, two octal digits packed into six bits.
`define PIS_OP_END 6'h00
`define PIS_OP_IND1 6'h04
`define PIS_OP_OFF 6'h05
`define PIS_OP_NOP 6'h07
`define PIS_OP_IFNEG 6'h08
`define PIS_OP_IFPOS 6'h09
`define PIS_OP_EXT 6'h0a
`define PIS_OP_GOSUB 6'h0b
`define PIS_OP_IND2 6'h0c
`define PIS_OP_RET 6'h0d
`define PIS_OP_CLRD 6'h0e
`define PIS_OP_GOTO 6'h0f
`define PIS_OP_SQSX 6'h30
`define PIS_OP_INTX 6'h31
`define PIS_OP_LDSQS 6'h32
`define PIS_OP_LDINT 6'h33
`define PIS_OP_XY 6'h35
`define PIS_OP_CLRX 6'h36
`define PIS_OP_CPY 6'h37
`define PIS_OP_PIX 6'h38
`define PIS_OP_DX 6'h39
`define PIS_OP_LDPI 6'h3a
`define PIS_OP_LDD 6'h3b
`define PIS_OP_XZ 6'h3d
`define PIS_OP_CLRXYZ 6'h3e
`define PIS_OP_LDZ 6'h3f
// ============================================================
// Data register file layout and timing counts.
`define PIS_NSTORE 4'h6
`define PIS_TW_LO 4'h6
`define PIS_TW_HI 4'h8
`define PIS_STB_CYC 4
`endif

//--- hw/pis_data_mem.v
// ============================================================
// Data register file with registered read data.
module pis_data_mem #(
  parameter W = 32,
  parameter DEPTH = 16,
  parameter AB = 4
) (
  // Clock.
  input wire clk_i,
  // Single port.
  input wire [AB-1:0] addr_i,
  input wire we_i,
  input wire [W-1:0] wdata_i,
  output reg [W-1:0] rdata_o
);
  reg [W-1:0] mem [0:DEPTH-1];

  // No reset: contents are volatile, as in the original storage.
  always @(posedge clk_i) begin
    if (we_i) begin
      mem[addr_i] <= wdata_i;
    end
    rdata_o <= mem[addr_i];
  end
endmodule // pis_data_mem

//--- hw/pis_sequencer.v
// Behaviour
// (RL1) Step 65 swaps x and y, nothing else changes.
// (RL2) Step 75 swaps x and z.
// (RL3) Step 70 swaps the plug-in measurement register with x.
// (RL4) Step 61 swaps internal with x; step 60 swaps sqs with x.
// (RL5) Step 71 swaps x with the data register named by the next step.
// (RL6) Step 67 copies x to y; step 62 also loads x from sqs.
// (RL7) Step 73 copies x to y, loads x from the named data register.
// (RL8) Steps 72, 63, 77 copy x to y, load x from pi, int, z.
// (RL9) Step 50 requests display of x, changing no register.
// (RL10) Step 04 lights indicator one, step 14 indicator two.
// (RL11) Step 05 or the panel reset button turns both indicators off; a step 04 or 14 executed in the same cycle wins over the button.
// (RL12) Step 12 drives the next step's digit, inverted, on four lines.
// (RL13) A strobe pulse accompanies each new four-line code.
// (RL14) The code step stalls while the active-low holdoff is low.
// (RL15) Step 00 ends the program and restarts at the start address.
// (RL16) Step 46 commands the mainframe self-check subprogram.
// (RL17) Step 47 commands the mainframe calibrate subprogram.
// (RL18) Steps 10 and 11 test x sign; failing test skips next step.
// (RL19) Step 13 reads three digits, lsd first, saves return, jumps.
// (RL20) Step 15 resumes after the digits of the latest call.
// (RL21) Step 17 jumps to the three-digit address, lsd first.
// (RL22) Step 66 clears x, 76 clears x y z, 16 clears storage.
// (RL23) Step 07 does nothing but advance.
// (RL24) One saved return address; nested calls overwrite it.
//
// Local design decisions: the register offsets and the Wishbone slave port.
`include "pis_regs.vh"
module pis_sequencer #(
  parameter W = 32,
  parameter AW = 8,
  parameter STB_CYC = `PIS_STB_CYC
) (
  // Clock and reset.
  input wire clk_i,
  input wire rst_i,
  // Wishbone slave.
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  // Program store and front panel.
  output reg [AW-1:0] prog_addr_o,
  input wire [5:0] prog_data_i,
  input wire [AW-1:0] start_addr_i,
  input wire panel_reset_i,
  output reg indicator_one_on_o,
  output reg indicator_two_on_o,
  // Mainframe command handshake.
  output reg [5:0] mf_op_o,
  output reg mf_req_o,
  input wire mf_done_i,
  output reg [W-1:0] x_o,
  // Auxiliary port.
  output reg [3:0] ext_code_n_o,
  output reg ext_strobe_o,
  input wire holdoff_n_i
);
  // ============================================================
  // States.
  localparam S_IDLE = 4'h0;
  localparam S_FETCH = 4'h1;
  localparam S_WAIT = 4'h2;
  localparam S_LATCH = 4'h3;
  localparam S_EXEC = 4'h4;
  localparam S_MEMRD = 4'h5;
  localparam S_MEMWB = 4'h6;
  localparam S_CLR = 4'h7;
  localparam S_EXT = 4'h8;
  localparam S_HOLD = 4'h9;
  localparam S_MF = 4'ha;

  reg [3:0] state;
  reg [AW-1:0] pc;
  reg [AW-1:0] ret_addr;
  reg [5:0] op;
  reg [1:0] phase;
  reg [11:0] digs;
  reg [3:0] clr_idx;
  reg [7:0] stb_cnt;
  reg run;
  reg wb_rd1;
  reg [W-1:0] y;
  reg [W-1:0] z;
  reg [W-1:0] pi_r;
  reg [W-1:0] int_r;
  reg [W-1:0] sqs;
  reg [1:0] n_opnd;
  reg [3:0] seq_maddr;
  reg seq_mwe;
  reg [W-1:0] seq_mwd;

  wire idle = (state == S_IDLE);
  wire [3:0] dsel = digs[11:8];
  wire [3:0] nxt = run ? S_FETCH : S_IDLE;
  wire [9:0] tgt = {6'h00, digs[3:0]} + digs[7:4] * 10'h00a
    + digs[11:8] * 10'h064;
  wire [AW-1:0] pc_inc = pc + {{(AW-1){1'b0}}, 1'b1};
  wire wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire wb_data = wb_adr_i[6];
  wire [W-1:0] m_rdata;
  wire [3:0] m_addr = idle ? wb_adr_i[5:2] : seq_maddr;
  wire m_we = idle ? (wb_req & wb_we_i & wb_data & wb_sel_i[0]) : seq_mwe;
  wire [W-1:0] m_wd = idle ? wb_dat_i[W-1:0] : seq_mwd;
  wire dsel_tw = (dsel >= `PIS_TW_LO) && (dsel <= `PIS_TW_HI);

  // ============================================================
  // Operand count per step code.
  always @* begin
    n_opnd = 2'd0;
    if (prog_data_i == `PIS_OP_EXT || prog_data_i == `PIS_OP_DX ||
        prog_data_i == `PIS_OP_LDD) begin
      n_opnd = 2'd1;
    end else if (prog_data_i == `PIS_OP_GOSUB ||
                 prog_data_i == `PIS_OP_GOTO) begin
      n_opnd = 2'd3;
    end
  end

  // ============================================================
  // Sequencer side of the data register file.
  always @* begin
    seq_maddr = dsel;
    seq_mwe = 1'b0;
    seq_mwd = x_o;
    if (state == S_CLR) begin
      seq_maddr = clr_idx;
      seq_mwe = 1'b1; // [RL22]
      seq_mwd = {W{1'b0}};
    end else if (state == S_MEMWB && op == `PIS_OP_DX) begin
      // Thumbwheel switches are read-only, so a swap only reads them.
      seq_mwe = ~dsel_tw; // [RL5]
    end
  end

  pis_data_mem #(
    .W(W),
    .DEPTH(16),
    .AB(4)
  ) u_mem (
    .clk_i(clk_i),
    .addr_i(m_addr),
    .we_i(m_we),
    .wdata_i(m_wd),
    .rdata_o(m_rdata)
  );

  // ============================================================
  // Sequencer and register slave share one process, because the
  // working registers are loaded by both while only one is active.
  always @(posedge clk_i) begin
    if (rst_i) begin
      state <= S_IDLE;
      pc <= {AW{1'b0}};
      ret_addr <= {AW{1'b0}};
      op <= 6'h00;
      phase <= 2'd0;
      digs <= 12'h000;
      clr_idx <= 4'h0;
      stb_cnt <= 8'h00;
      run <= 1'b0;
      wb_rd1 <= 1'b0;
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
      x_o <= {W{1'b0}};
      y <= {W{1'b0}};
      z <= {W{1'b0}};
      pi_r <= {W{1'b0}};
      int_r <= {W{1'b0}};
      sqs <= {W{1'b0}};
      prog_addr_o <= {AW{1'b0}};
      indicator_one_on_o <= 1'b0;
      indicator_two_on_o <= 1'b0;
      mf_op_o <= 6'h00;
      mf_req_o <= 1'b0;
      ext_code_n_o <= 4'hf;
      ext_strobe_o <= 1'b0;
    end else begin
      wb_ack_o <= 1'b0;
      if (wb_req) begin
        if (wb_data && idle && !wb_we_i && !wb_rd1) begin
          wb_rd1 <= 1'b1;
        end else begin
          wb_ack_o <= 1'b1;
          wb_rd1 <= 1'b0;
          wb_dat_o <= 32'h0000_0000;
          if (wb_data) begin
            if (idle) begin
              wb_dat_o <= m_rdata;
            end
          end else if (wb_adr_i == `PIS_ADR_CTRL) begin
            wb_dat_o[`PIS_CTRL_RUN] <= run;
            if (wb_we_i && wb_sel_i[0]) begin
              run <= wb_dat_i[`PIS_CTRL_RUN];
            end
          end else if (wb_adr_i == `PIS_ADR_STAT) begin
            wb_dat_o[`PIS_STAT_BUSY] <= ~idle;
            wb_dat_o[`PIS_STAT_HOLD] <= (state == S_HOLD);
            wb_dat_o[`PIS_STAT_IND1] <= indicator_one_on_o;
            wb_dat_o[`PIS_STAT_IND2] <= indicator_two_on_o;
            wb_dat_o[`PIS_STAT_ST+3:`PIS_STAT_ST] <= state;
            wb_dat_o[`PIS_STAT_PC+AW-1:`PIS_STAT_PC] <= pc;
          end else if (wb_adr_i == `PIS_ADR_X) begin
            wb_dat_o <= x_o;
            if (wb_we_i && idle) begin
              x_o <= wb_dat_i;
            end
          end else if (wb_adr_i == `PIS_ADR_Y) begin
            wb_dat_o <= y;
            if (wb_we_i && idle) begin
              y <= wb_dat_i;
            end
          end else if (wb_adr_i == `PIS_ADR_Z) begin
            wb_dat_o <= z;
            if (wb_we_i && idle) begin
              z <= wb_dat_i;
            end
          end else if (wb_adr_i == `PIS_ADR_PI) begin
            wb_dat_o <= pi_r;
            if (wb_we_i && idle) begin
              pi_r <= wb_dat_i;
            end
          end else if (wb_adr_i == `PIS_ADR_INT) begin
            wb_dat_o <= int_r;
            if (wb_we_i && idle) begin
              int_r <= wb_dat_i;
            end
          end else if (wb_adr_i == `PIS_ADR_SQS) begin
            wb_dat_o <= sqs;
            if (wb_we_i && idle) begin
              sqs <= wb_dat_i;
            end
          end
        end
      end

      if (panel_reset_i) begin
        indicator_one_on_o <= 1'b0; // [RL11]
        indicator_two_on_o <= 1'b0; // [RL11]
      end

      case (state)
        S_IDLE: begin
          if (run) begin
            pc <= start_addr_i;
            phase <= 2'd0;
            state <= S_FETCH;
          end
        end
        S_FETCH: begin
          prog_addr_o <= pc;
          pc <= pc_inc;
          state <= S_WAIT;
        end
        S_WAIT: begin
          state <= S_LATCH;
        end
        S_LATCH: begin
          if (phase == 2'd0) begin
            op <= prog_data_i;
            phase <= n_opnd;
            state <= (n_opnd == 2'd0) ? S_EXEC : S_FETCH;
          end else begin
            // Digits shift in from the top, so the first one ends lowest.
            digs <= {prog_data_i[3:0], digs[11:4]}; // [RL19] [RL21]
            phase <= phase - 2'd1;
            state <= (phase == 2'd1) ? S_EXEC : S_FETCH;
          end
        end
        S_EXEC: begin
          state <= nxt;
          if (op == `PIS_OP_XY) begin
            x_o <= y; // [RL1]
            y <= x_o; // [RL1]
          end else if (op == `PIS_OP_XZ) begin
            x_o <= z; // [RL2]
            z <= x_o; // [RL2]
          end else if (op == `PIS_OP_PIX) begin
            x_o <= pi_r; // [RL3]
            pi_r <= x_o; // [RL3]
          end else if (op == `PIS_OP_INTX) begin
            x_o <= int_r; // [RL4]
            int_r <= x_o; // [RL4]
          end else if (op == `PIS_OP_SQSX) begin
            x_o <= sqs; // [RL4]
            sqs <= x_o; // [RL4]
          end else if (op == `PIS_OP_DX || op == `PIS_OP_LDD) begin
            state <= S_MEMRD; // [RL5] [RL7]
          end else if (op == `PIS_OP_CPY) begin
            y <= x_o; // [RL6]
          end else if (op == `PIS_OP_LDSQS) begin
            y <= x_o; // [RL6]
            x_o <= sqs; // [RL6]
          end else if (op == `PIS_OP_LDPI) begin
            y <= x_o; // [RL8]
            x_o <= pi_r; // [RL8]
          end else if (op == `PIS_OP_LDINT) begin
            y <= x_o; // [RL8]
            x_o <= int_r; // [RL8]
          end else if (op == `PIS_OP_LDZ) begin
            y <= x_o; // [RL8]
            x_o <= z; // [RL8]
          end else if (op == `PIS_OP_IND1) begin
            indicator_one_on_o <= 1'b1; // [RL10]
          end else if (op == `PIS_OP_IND2) begin
            indicator_two_on_o <= 1'b1; // [RL10]
          end else if (op == `PIS_OP_OFF) begin
            indicator_one_on_o <= 1'b0; // [RL11]
            indicator_two_on_o <= 1'b0; // [RL11]
          end else if (op == `PIS_OP_EXT) begin
            ext_code_n_o <= ~dsel; // [RL12]
            ext_strobe_o <= 1'b1; // [RL13]
            stb_cnt <= STB_CYC[7:0] - 8'h01;
            state <= S_EXT;
          end else if (op == `PIS_OP_END) begin
            pc <= start_addr_i; // [RL15]
          end else if (op == `PIS_OP_IFNEG) begin
            if (!x_o[W-1]) begin
              pc <= pc_inc; // [RL18]
            end
          end else if (op == `PIS_OP_IFPOS) begin
            if (x_o[W-1] || x_o == {W{1'b0}}) begin
              pc <= pc_inc; // [RL18]
            end
          end else if (op == `PIS_OP_GOSUB) begin
            ret_addr <= pc; // [RL19] [RL24]
            pc <= tgt[AW-1:0]; // [RL19]
          end else if (op == `PIS_OP_RET) begin
            pc <= ret_addr; // [RL20]
          end else if (op == `PIS_OP_GOTO) begin
            pc <= tgt[AW-1:0]; // [RL21]
          end else if (op == `PIS_OP_CLRX) begin
            x_o <= {W{1'b0}}; // [RL22]
          end else if (op == `PIS_OP_CLRXYZ) begin
            x_o <= {W{1'b0}}; // [RL22]
            y <= {W{1'b0}}; // [RL22]
            z <= {W{1'b0}}; // [RL22]
          end else if (op == `PIS_OP_CLRD) begin
            clr_idx <= 4'h0;
            state <= S_CLR;
          end else if (op == `PIS_OP_NOP) begin
            state <= nxt; // [RL23]
          end else begin
            // Display, self-check, calibrate and every step this block
            // does not decode are handed to the mainframe.
            mf_op_o <= op; // [RL9] [RL16] [RL17]
            mf_req_o <= 1'b1;
            state <= S_MF;
          end
        end
        S_MEMRD: begin
          state <= S_MEMWB;
        end
        S_MEMWB: begin
          x_o <= m_rdata; // [RL5] [RL7]
          if (op == `PIS_OP_LDD) begin
            y <= x_o; // [RL7]
          end
          state <= nxt;
        end
        S_CLR: begin
          clr_idx <= clr_idx + 4'h1;
          if (clr_idx == `PIS_NSTORE - 4'h1) begin
            state <= nxt;
          end
        end
        S_EXT: begin
          if (stb_cnt == 8'h00) begin
            ext_strobe_o <= 1'b0; // [RL13]
            state <= S_HOLD;
          end else begin
            stb_cnt <= stb_cnt - 8'h01;
          end
        end
        S_HOLD: begin
          if (holdoff_n_i) begin
            state <= nxt; // [RL14]
          end
        end
        S_MF: begin
          if (mf_done_i) begin
            mf_req_o <= 1'b0;
            state <= nxt;
          end
        end
        default: begin
          state <= S_IDLE;
        end
      endcase
    end
  end
endmodule // pis_sequencer

//--- verif/pis_seq_monitor.sv
// ====
// Port checker for the sequencer.
module pis_seq_monitor #(
  parameter W = 32,
  parameter AW = 8,
  parameter STB_CYC = 4
) (
  // Clock and reset.
  input wire clk_i,
  input wire rst_i,
  // Bus handshake.
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_ack_o,
  // Sequencer side.
  input wire [AW-1:0] prog_addr_o,
  input wire [5:0] mf_op_o,
  input wire mf_req_o,
  input wire mf_done_i,
  input wire [W-1:0] x_o,
  input wire [3:0] ext_code_n_o,
  input wire ext_strobe_o,
  input wire holdoff_n_i
);
  timeunit 1ns;
  timeprecision 1ps;
  int stb_cnt;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // A counter keeps the strobe width check free of long repetitions.
  always @(posedge clk_i) begin
    if (rst_i || !ext_strobe_o) stb_cnt <= 0;
    else stb_cnt <= stb_cnt + 1;
  end
  sequence s_wait;
    mf_req_o && !mf_done_i;
  endsequence
  sequence s_stall;
    $fell(ext_strobe_o) ##0 !holdoff_n_i ##1 !holdoff_n_i;
  endsequence
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held too long");
  a_ack_held: assert property (wb_ack_o |-> wb_cyc_i && wb_stb_i)
    else $error("ack without request");
  a_ack_bound: assert property
    (wb_cyc_i && wb_stb_i && !wb_ack_o |-> ##[1:2] wb_ack_o)
    else $error("ack late");
  a_strobe_width: assert property
    ($fell(ext_strobe_o) |-> stb_cnt == STB_CYC)
    else $error("strobe width wrong");
  a_code_cause: assert property
    ($changed(ext_code_n_o) |-> $rose(ext_strobe_o))
    else $error("code moved without strobe");
  a_hold_stall: assert property (s_stall |-> $stable(prog_addr_o))
    else $error("program moved during holdoff");
  a_mf_wait: assert property
    (s_wait |=> mf_req_o && $stable(mf_op_o))
    else $error("request dropped early");
  a_mf_drop: assert property (mf_req_o && mf_done_i |=> !mf_req_o)
    else $error("request kept after done");
  a_show_keeps: assert property
    (mf_req_o && mf_op_o == 6'h28 |-> $stable(x_o))
    else $error("display changed x");
endmodule // pis_seq_monitor

bind pis_sequencer pis_seq_monitor #(.W(W), .AW(AW), .STB_CYC(STB_CYC))
  u_mon (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .prog_addr_o,
  .mf_op_o, .mf_req_o, .mf_done_i, .x_o, .ext_code_n_o, .ext_strobe_o,
  .holdoff_n_i);

//--- verif/pis_far_model.sv
// ====
// Program store, mainframe and auxiliary instrument.
module pis_far_model #(
  parameter int MF_LAT = 3,
  parameter int HOLD = 6
) (
  // Clock.
  input wire logic clk_i,
  // Program store.
  input wire logic [7:0] prog_addr_i,
  output logic [5:0] prog_data_o,
  // Mainframe.
  input wire logic [5:0] mf_op_i,
  input wire logic mf_req_i,
  output logic mf_done_o,
  // Instrument.
  input wire logic ext_strobe_i,
  output logic holdoff_n_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [5:0] rom [256];
  logic [5:0] ops [$];
  int mc = 0;
  int hc = 0;
  initial begin
    foreach (rom[i]) rom[i] = 6'h00;
    prog_data_o = 6'h00;
    mf_done_o = 1'b0;
    holdoff_n_o = 1'b1;
  end
  always @(posedge clk_i) begin
    prog_data_o <= rom[prog_addr_i];
    if (mf_req_i && !mf_done_o) begin
      mc <= mc + 1;
      if (mc == MF_LAT) begin
        mf_done_o <= 1'b1;
        ops.push_back(mf_op_i);
        mc <= 0;
      end
    end else mf_done_o <= 1'b0;
    // Slow on purpose so that the stall is seen.
    if (ext_strobe_i) begin
      hc <= HOLD;
      holdoff_n_o <= 1'b0;
    end else if (hc > 0) hc <= hc - 1;
    else holdoff_n_o <= 1'b1;
  end
endmodule // pis_far_model

//--- verif/pis_sequencer_tb.sv
module pis_sequencer_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int STB = 4;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'hf;
  logic [31:0] wb_dat_i = 32'h0000_0000;
  logic [7:0] start_addr_i = 8'h0a;
  logic panel_reset_i = 1'b0;
  logic [31:0] wb_dat_o, x_o;
  logic wb_ack_o, indicator_one_on_o, indicator_two_on_o;
  logic [7:0] prog_addr_o;
  logic [5:0] prog_data_i, mf_op_o;
  logic mf_req_o, mf_done_i, ext_strobe_o, holdoff_n_i;
  logic [3:0] ext_code_n_o;
  logic leak = 1'b0;
  int miscompares = 0;
  int samples_checked = 0;
  int sc = 0;
  wire [31:0] lamps = {30'h0000_0000, indicator_two_on_o, indicator_one_on_o};
  pis_sequencer #(.STB_CYC(STB)) dut (
    .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
    .wb_dat_i, .wb_dat_o, .wb_ack_o, .prog_addr_o, .prog_data_i,
    .start_addr_i, .panel_reset_i, .indicator_one_on_o,
    .indicator_two_on_o, .mf_op_o, .mf_req_o, .mf_done_i, .x_o,
    .ext_code_n_o, .ext_strobe_o, .holdoff_n_i
  );
  pis_far_model u_far (
    .clk_i, .prog_addr_i(prog_addr_o), .prog_data_o(prog_data_i),
    .mf_op_i(mf_op_o), .mf_req_i(mf_req_o), .mf_done_o(mf_done_i),
    .ext_strobe_i(ext_strobe_o), .holdoff_n_o(holdoff_n_i)
  );
  initial begin
    forever #12.5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    if (ext_strobe_o === 1'b1) sc <= sc + 1;
    if (holdoff_n_i === 1'b0 && prog_addr_o inside {8'h0c, 8'h0e}) leak <= 1;
  end
  // ====
  // Shared helpers.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wb(input logic we, input logic [7:0] a,
                    input logic [31:0] d, output logic [31:0] q);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    @(posedge clk_i);
    for (int n = 0; n < 50 && wb_ack_o !== 1'b1; n++) @(posedge clk_i);
    if (wb_ack_o !== 1'b1) miscompares++;
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    wb(1'b0, a, 32'h0000_0000, q);
    chk(q, e);
  endtask
  task automatic ld(input logic [7:0] a, input int n, input logic [47:0] v);
    for (int i = 0; i < n; i++) u_far.rom[a + i] = v[6 * (n - 1 - i) +: 6];
  endtask
  task automatic wt(input logic [7:0] a);
    for (int n = 0; n < 900 && prog_addr_o !== a; n++) @(posedge clk_i);
    if (prog_addr_o !== a) miscompares++;
  endtask
  // Clearing run only stops at a step boundary, so poll busy after.
  task automatic run(input logic [7:0] m);
    logic [31:0] q;
    wr(8'h00, 32'h0000_0001);
    wt(start_addr_i);
    wt(m);
    wr(8'h00, 32'h0000_0000);
    q = 32'h0000_0001;
    for (int n = 0; n < 40 && q[0] !== 1'b0; n++)
      wb(1'b0, 8'h04, 32'h0000_0000, q);
    if (q[0] !== 1'b0) miscompares++;
  endtask
  // ====
  // Scenarios.
  task automatic t_reset();
    chk(32'(ext_code_n_o), 32'h0000_000f);
    chk(lamps, 32'h0000_0000);
    wr(8'h04, 32'hffff_ffff);
    rc(8'h04, 32'h0000_0000);
    rc(8'h30, 32'h0000_0000);
  endtask
  task automatic t_xfer();
    logic [5:0] ops [12] = '{6'h35, 6'h3d, 6'h38, 6'h31, 6'h30, 6'h37,
                             6'h32, 6'h3a, 6'h33, 6'h3f, 6'h36, 6'h3e};
    int idx [12] = '{1, 2, 3, 4, 5, 0, 5, 3, 4, 2, 0, 0};
    logic [31:0] e [6];
    for (int k = 0; k < 12; k++) begin
      for (int i = 0; i < 6; i++) begin
        e[i] = 32'(i + 1);
        wr(8'(8 + 4 * i), e[i]);
      end
      ld(8'h0a, 3, {ops[k], 6'h07, 6'h00});
      if (k < 5) e[idx[k]] = 32'h0000_0001;
      if (k >= 5 && k < 10) e[1] = 32'h0000_0001;
      e[0] = (k < 10) ? 32'(idx[k] + 1) : 32'h0000_0000;
      if (k == 11) e[1] = 32'h0000_0000;
      if (k == 11) e[2] = 32'h0000_0000;
      run(8'h0b);
      for (int i = 0; i < 6; i++)
        rc(8'(8 + 4 * i), e[i]);
    end
  endtask
  task automatic t_data();
    wr(8'h08, 32'h0000_0001);
    wr(8'h48, 32'h0000_0009);
    wr(8'h58, 32'h0000_0007);
    wr(8'h40, 32'h0000_0005);
    ld(8'h0a, 7, {6'h39, 6'h12, 6'h3b, 6'h12, 6'h0e, 6'h07, 6'h00});
    run(8'h0f);
    rc(8'h08, 32'h0000_0001);
    rc(8'h0c, 32'h0000_0009);
    rc(8'h40, 32'h0000_0000);
    rc(8'h48, 32'h0000_0000);
    rc(8'h58, 32'h0000_0007);
  endtask
  task automatic t_branch();
    wr(8'h08, 32'h8000_0000);
    ld(8'h0a, 5, {6'h08, 6'h04, 6'h09, 6'h0c, 6'h0f});
    ld(8'h0f, 4, {6'h10, 6'h13, 6'h10, 6'h05});
    ld(8'h1e, 7, {6'h0b, 6'h10, 6'h15, 6'h10, 6'h26, 6'h07, 6'h00});
    ld(8'h32, 3, {6'h28, 6'h27, 6'h0d});
    u_far.ops.delete();
    run(8'h23);
    chk(lamps, 32'h0000_0001);
    chk(32'(u_far.ops.size()), 32'h0000_0003);
    chk(32'(u_far.ops[0]), 32'h0000_0028);
    chk(32'(u_far.ops[1]), 32'h0000_0027);
    chk(32'(u_far.ops[2]), 32'h0000_0026);
    rc(8'h08, 32'h8000_0000);
  endtask
  task automatic t_lamps();
    panel_reset_i <= 1'b1;
    @(posedge clk_i);
    panel_reset_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    chk(lamps, 32'h0000_0000);
    ld(8'h0a, 3, {6'h0c, 6'h07, 6'h00});
    run(8'h0b);
    chk(lamps, 32'h0000_0002);
    ld(8'h0a, 3, {6'h05, 6'h07, 6'h00});
    run(8'h0b);
    chk(lamps, 32'h0000_0000);
  endtask
  task automatic t_ext();
    ld(8'h0a, 6, {6'h0a, 6'h1a, 6'h0a, 6'h13, 6'h07, 6'h00});
    run(8'h0e);
    chk(32'(ext_code_n_o), 32'h0000_000c);
    chk(32'(sc), 32'(2 * STB));
    chk(32'(leak), 32'h0000_0000);
  endtask
  task automatic t_end();
    start_addr_i <= 8'h14;
    ld(8'h14, 2, {6'h07, 6'h00});
    wr(8'h00, 32'h0000_0001);
    wt(8'h14);
    wt(8'h15);
    wt(8'h14);
    chk(32'(prog_addr_o), 32'h0000_0014);
    wr(8'h00, 32'h0000_0000);
  endtask
  task automatic close_out();
    $display("miscompares=%0d samples_checked=%0d", miscompares,
             samples_checked);
    if (miscompares == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge clk_i);
    miscompares++;
    close_out();
  end
  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_reset();
    t_xfer();
    t_data();
    t_branch();
    t_lamps();
    t_ext();
    t_end();
    close_out();
  end
endmodule // pis_sequencer_tb
